// [verilog/nfc_pkg.sv]
// Package for the NAND feature set/get host controller
package nfc_pkg;
  // Device command codes
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RD_MODE = 8'h00;
  // Feature addresses
  localparam logic [7:0] FA_TIMING = 8'h01;
  localparam logic [7:0] FA_DRIVE = 8'h80;
  localparam logic [7:0] FA_RB_PULL = 8'h81;
  localparam logic [7:0] FA_ARRAY = 8'h90;
  // Parameter field masks and values
  localparam logic [7:0] TIMING_MODE_MASK = 8'h07;
  localparam logic [7:0] TIMING_MODE_MAX = 8'h05;
  localparam logic [7:0] DRIVE_MASK = 8'h03;
  localparam logic [7:0] ARRAY_MASK = 8'h1B;
  localparam logic [7:0] ARRAY_ECC_ON = 8'h08;
  localparam logic [7:0] ARRAY_OTP_MASK = 8'h03;
  localparam logic [7:0] ARRAY_OTP_BAD = 8'h02;
  localparam logic [7:0] ARRAY_LOCK_OFF = 8'h10;
  localparam logic [7:0] STATUS_LOCK_REPEAT = 8'h60;
  localparam int SR_READY_BIT = 6;
  localparam int SR_FAIL_BIT = 0;
  localparam logic [7:0] FEAT_RESET = 8'h00;
  // Host-side Wishbone registers (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_GET_BIT = 1;
  localparam int CTRL_POLL_BIT = 2;
  // Timing: 125 MHz clock, 8 ns period
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ADL_WAIT_PS = 70000;
  localparam int ADL_CYC = (ADL_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_PS = 25000;
  localparam int STROBE_CYC = (STROBE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WB_PS = 100;
  localparam int WB_CYC = (WB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam int NUM_PARAMS = 4;
  // Bus cycle kinds driven onto the flash pins
  typedef enum logic [1:0] {
    CYC_CMD = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_WRITE = 2'b10,
    CYC_READ = 2'b11
  } nfc_cyc_type;
  // Flash pin bundle driven by the host
  typedef struct packed {
    logic ceN;
    logic cle;
    logic ale;
    logic weN;
    logic read_strobe_n;
    logic [7:0] dqOut;
    logic dqOe;
  } nfc_pins_type;
  // One bus cycle request to the pin sequencer
  typedef struct packed {
    nfc_cyc_type kind;
    logic [7:0] data;
  } nfc_req_type;
endpackage : nfc_pkg

// [verilog/nfc_cycle.sv]
// Pin sequencer: one command, address, write or read cycle on the flash bus
`timescale 1ns/1ps
`default_nettype none
module nfc_cycle
  import nfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request side
  input wire logic reqValid,
  input wire nfc_req_type req,
  output logic reqReady,
  output logic doneP,
  output logic [7:0] rdData,
  // Flash pins
  output nfc_pins_type pins,
  input wire logic [7:0] dqIn
);
  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  nfc_req_type cur_r;
  logic [7:0] rdData_r;
  logic done_r;

  assign reqReady = !busy_r;
  assign doneP = done_r;
  assign rdData = rdData_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cur_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
      rdData_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && reqValid) begin
        busy_r <= 1'b1;
        cur_r <= req;
        cnt_r <= CNT_W'(2 * STROBE_CYC);
      end else if (busy_r) begin
        // Read data sampled in the last strobe-low cycle; the target lets go once it rises
        if (cnt_r == CNT_W'(STROBE_CYC + 1) && cur_r.kind == CYC_READ) begin
          rdData_r <= dqIn;
        end
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  // Strobe low in the first half of the cycle; a write latches on the rising edge
  logic strobeLow;
  assign strobeLow = busy_r && (cnt_r > CNT_W'(STROBE_CYC));
  always_comb begin
    pins.ceN = 1'b0;
    pins.cle = busy_r && cur_r.kind == CYC_CMD;
    pins.ale = busy_r && cur_r.kind == CYC_ADDR;
    pins.weN = !(strobeLow && cur_r.kind != CYC_READ);
    pins.read_strobe_n = !(strobeLow && cur_r.kind == CYC_READ);
    pins.dqOut = cur_r.data;
    pins.dqOe = !(busy_r && cur_r.kind != CYC_READ);
  end
endmodule : nfc_cycle
`default_nettype wire

// [verilog/nfc_host.sv]
// Host controller issuing set/get features to an asynchronous NAND target
// Summary of operation
// - EFh/EEh, one address, four parameter bytes
// - Host waits address-to-data time before data
// - Busy after address, then host reads four
// - After 70h polling, issue 00h before reading
// - Host never issues 78h during get-features
`timescale 1ns/1ps
`default_nettype none
module nfc_host
  import nfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Flash pins
  output nfc_pins_type pins,
  input wire logic [7:0] dqIn,
  input wire logic readyBusyN
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_ADL = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_BUSY = 4'b0101,
    ST_POLL_CMD = 4'b0110,
    ST_POLL_RD = 4'b0111,
    ST_RDMODE = 4'b1000,
    ST_RDATA = 4'b1001,
    ST_DONE = 4'b1010
  } nfc_state_type;

  nfc_state_type state_r;
  logic isGet_r, usePoll_r;
  logic [7:0] feat_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] idx_r;
  logic [CNT_W-1:0] wait_r;
  logic busy_r, err_r, lockRepeat_r;
  logic [7:0] status_r;
  logic issued_r;
  logic go;

  // Sequencer link
  logic reqValid, reqReady, doneP;
  nfc_req_type req;
  logic [7:0] cycData;

  nfc_cycle u_cycle (
    .clk(clk),
    .nrst(nrst),
    .reqValid(reqValid),
    .req(req),
    .reqReady(reqReady),
    .doneP(doneP),
    .rdData(cycData),
    .pins(pins),
    .dqIn(dqIn)
  );

  // Reserved bits masked to zero before the device sees them
  function automatic logic [7:0] legal_p1(input logic [7:0] fa, input logic [7:0] p);
    if (fa == FA_TIMING) begin
      legal_p1 = (p & TIMING_MODE_MASK) > TIMING_MODE_MAX ? FEAT_RESET : (p & TIMING_MODE_MASK);
    end else if (fa == FA_DRIVE || fa == FA_RB_PULL) begin
      legal_p1 = p & DRIVE_MASK;
    end else if (fa == FA_ARRAY) begin
      // 02h is no defined OTP code; fall back to normal access
      legal_p1 = ((p & ARRAY_OTP_MASK) == ARRAY_OTP_BAD) ? (p & ARRAY_MASK & ~ARRAY_OTP_MASK)
                 : (p & ARRAY_MASK);
    end else begin
      legal_p1 = p;
    end
  endfunction : legal_p1

  function automatic logic known_feat(input logic [7:0] fa);
    known_feat = (fa == FA_TIMING) || (fa == FA_DRIVE) || (fa == FA_RB_PULL) || (fa == FA_ARRAY);
  endfunction : known_feat

  // Wishbone: ack one cycle after the strobe, dropped the next
  logic wbHit;
  assign wbHit = wbCyc && wbStb && !wbAck;
  assign go = wbHit && wbWe && wbAdr == REG_CTRL && wbSel[0] && wbDatW[CTRL_GO_BIT]
              && !busy_r && known_feat(feat_r);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
    end else begin
      wbAck <= wbHit;
      if (wbHit && !wbWe) begin
        if (wbAdr == REG_CTRL) begin
          wbDatR <= {31'h0000_0000, busy_r};
        end else if (wbAdr == REG_ADDR) begin
          wbDatR <= {24'h00_0000, feat_r};
        end else if (wbAdr == REG_WDATA) begin
          wbDatR <= wdata_r;
        end else if (wbAdr == REG_RDATA) begin
          wbDatR <= rdata_r;
        end else if (wbAdr == REG_STATUS) begin
          wbDatR <= {16'h0000, status_r, 5'h00, lockRepeat_r, err_r, busy_r};
        end else begin
          wbDatR <= 32'h0000_0000;
        end
      end
    end
  end

  // Software setup registers; power-on feature values are all 00h
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      feat_r <= FA_TIMING;
      wdata_r <= 32'h0000_0000;
      isGet_r <= 1'b0;
      usePoll_r <= 1'b0;
    end else if (wbHit && wbWe && !busy_r) begin
      if (wbAdr == REG_ADDR && wbSel[0]) begin
        feat_r <= wbDatW[7:0];
      end else if (wbAdr == REG_WDATA) begin
        for (int b = 0; b < 4; b++) begin
          if (wbSel[b]) wdata_r[8*b +: 8] <= wbDatW[8*b +: 8];
        end
      end else if (wbAdr == REG_CTRL && wbSel[0]) begin
        isGet_r <= wbDatW[CTRL_GET_BIT];
        usePoll_r <= wbDatW[CTRL_POLL_BIT];
      end
    end
  end

  // Cycle request decode for each state
  always_comb begin
    reqValid = 1'b0;
    req.kind = CYC_CMD;
    req.data = 8'h00;
    case (state_r)
      ST_CMD: begin
        reqValid = !issued_r;
        req.data = isGet_r ? CMD_GET_FEAT : CMD_SET_FEAT;
      end
      ST_ADDR: begin
        reqValid = !issued_r;
        req.kind = CYC_ADDR;
        req.data = feat_r;
      end
      ST_WDATA: begin
        reqValid = !issued_r;
        req.kind = CYC_WRITE;
        req.data = (idx_r == 2'd0) ? legal_p1(feat_r, wdata_r[7:0]) : 8'h00;
      end
      ST_POLL_CMD: begin
        reqValid = !issued_r;
        req.data = CMD_RD_STATUS;
      end
      ST_POLL_RD: begin
        reqValid = !issued_r;
        req.kind = CYC_READ;
      end
      ST_RDMODE: begin
        reqValid = !issued_r;
        req.data = CMD_RD_MODE;
      end
      ST_RDATA: begin
        reqValid = !issued_r;
        req.kind = CYC_READ;
      end
      default: begin
        reqValid = 1'b0;
      end
    endcase
  end

  // Main sequence; only EF/EE/70/00 are ever sent, never 78h
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      issued_r <= 1'b0;
      idx_r <= 2'd0;
      wait_r <= '0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      lockRepeat_r <= 1'b0;
      status_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (reqValid && reqReady) issued_r <= 1'b1;
      case (state_r)
        ST_IDLE: begin
          // The get bit is written on this same edge, so decide from the bus word
          if (go && (!wbDatW[CTRL_GET_BIT] || readyBusyN)) begin
            state_r <= ST_CMD;
            busy_r <= 1'b1;
            err_r <= 1'b0;
            lockRepeat_r <= 1'b0;
            idx_r <= 2'd0;
          end else if (go) begin
            err_r <= 1'b1;
          end
        end
        ST_CMD: if (doneP) begin
          issued_r <= 1'b0;
          state_r <= ST_ADDR;
        end
        ST_ADDR: if (doneP) begin
          issued_r <= 1'b0;
          wait_r <= CNT_W'(ADL_CYC);
          state_r <= isGet_r ? ST_BUSY : ST_ADL;
        end
        ST_ADL: begin
          if (wait_r == '0) state_r <= ST_WDATA;
          else wait_r <= wait_r - 1'b1;
        end
        ST_WDATA: if (doneP) begin
          issued_r <= 1'b0;
          idx_r <= idx_r + 1'b1;
          if (idx_r == 2'(NUM_PARAMS - 1)) begin
            state_r <= ST_BUSY;
            wait_r <= CNT_W'(WB_CYC);
          end
        end
        ST_BUSY: begin
          // Let R/B# fall before trusting it; covers feature and interface-change busy
          if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1;
          end else if (usePoll_r) begin
            state_r <= ST_POLL_CMD;
          end else if (readyBusyN) begin
            state_r <= isGet_r ? ST_RDATA : ST_DONE;
          end
        end
        ST_POLL_CMD: if (doneP) begin
          issued_r <= 1'b0;
          state_r <= ST_POLL_RD;
        end
        ST_POLL_RD: if (doneP) begin
          issued_r <= 1'b0;
          status_r <= cycData;
          if (cycData[SR_READY_BIT]) begin
            if (!isGet_r && cycData == STATUS_LOCK_REPEAT
                && feat_r == FA_ARRAY && (wdata_r[7:0] & ARRAY_LOCK_OFF) != 8'h00) begin
              lockRepeat_r <= 1'b1;
            end
            if (cycData[SR_FAIL_BIT]) err_r <= 1'b1;
            state_r <= isGet_r ? ST_RDMODE : ST_DONE;
          end
        end
        ST_RDMODE: if (doneP) begin
          issued_r <= 1'b0;
          state_r <= ST_RDATA;
        end
        ST_RDATA: if (doneP) begin
          issued_r <= 1'b0;
          rdata_r[8*idx_r +: 8] <= cycData;
          idx_r <= idx_r + 1'b1;
          if (idx_r == 2'(NUM_PARAMS - 1)) state_r <= ST_DONE;
        end
        ST_DONE: begin
          busy_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Assertions
  property p_adl;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_ADDR && doneP && !isGet_r) |=> (state_r == ST_ADL)[*2];
  endproperty
  a_adl: assert property (p_adl) else $error("data cycle before address wait");

  property p_no78;
    @(posedge clk) disable iff (!nrst)
      (pins.cle && !pins.dqOe) |-> pins.dqOut != 8'h78;
  endproperty
  a_no78: assert property (p_no78) else $error("enhanced status issued");

  property p_four;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_WDATA && doneP && idx_r == 2'd3) |=> state_r == ST_BUSY;
  endproperty
  a_four: assert property (p_four) else $error("busy not entered after fourth byte");

  property p_rdmode;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_POLL_RD && doneP && isGet_r && cycData[SR_READY_BIT]) |=> state_r == ST_RDMODE;
  endproperty
  a_rdmode: assert property (p_rdmode) else $error("read mode skipped after polling");

  property p_getidle;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_IDLE && go && wbDatW[CTRL_GET_BIT] && !readyBusyN) |=>
        state_r == ST_IDLE && err_r;
  endproperty
  a_getidle: assert property (p_getidle) else $error("get features started while busy");

  property p_tmode;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_WDATA && feat_r == FA_TIMING && reqValid) |-> req.data <= TIMING_MODE_MAX;
  endproperty
  a_tmode: assert property (p_tmode) else $error("illegal timing mode sent");

  property p_drive;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_WDATA && feat_r == FA_DRIVE && reqValid) |-> (req.data & ~DRIVE_MASK) == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("reserved drive bits set");

  property p_rest;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_WDATA && idx_r != 2'd0 && reqValid) |-> req.data == 8'h00;
  endproperty
  a_rest: assert property (p_rest) else $error("reserved parameter byte nonzero");

  property p_getcmd;
    @(posedge clk) disable iff (!nrst)
      (state_r == ST_CMD && reqValid) |-> req.data == (isGet_r ? CMD_GET_FEAT : CMD_SET_FEAT);
  endproperty
  a_getcmd: assert property (p_getcmd) else $error("wrong feature command code");
endmodule : nfc_host
`default_nettype wire

// [verification/nfc_flash_model.sv]
// Behavioural NAND target answering the feature commands
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int FEAT_NS = 800,
  parameter int ITC_NS = 1600,
  parameter int OBSY_NS = 1200,
  parameter int ADL_NS = 70
)(
  // Host pins
  input wire nfc_pins_type pins,
  output logic [7:0] dqIn,
  output logic readyBusyN,
  // Test controls
  input wire logic holdBusy,
  output logic [7:0] protoErr
);
  logic [31:0] mem [4] = '{default: 32'h0};
  logic [31:0] shift = 32'h0;
  logic [7:0] cmd = 8'h0, fa = 8'h0, lastOut = 8'h0, stReady = 8'hE0;
  logic busy = 1'b0, statusOut = 1'b0, lockOff = 1'b0;
  int nParam = 0;
  realtime addrTime = 0;
  wire logic [7:0] stat = busy ? 8'h80 : stReady;
  wire logic [7:0] driven = statusOut ? stat : shift[7:0];
  assign readyBusyN = ~(busy | holdBusy);
  // Released bus shows the inverse of the last byte, never a stale copy
  assign dqIn = pins.read_strobe_n ? ~lastOut : driven;
  initial protoErr = 8'h0;
  function automatic int idx(input logic [7:0] a);
    case (a)
      FA_TIMING: return 0;
      FA_DRIVE: return 1;
      FA_RB_PULL: return 2;
      FA_ARRAY: return 3;
      default: return -1;
    endcase
  endfunction : idx
  task automatic go_busy(input int ns);
    busy = 1'b1;
    fork
      begin
        #(ns);
        busy = 1'b0;
      end
    join_none
  endtask : go_busy
  always @(posedge pins.weN) begin
    if (pins.cle === 1'b1) begin
      if (pins.dqOut == 8'h78) protoErr++;
      if (pins.dqOut == CMD_GET_FEAT && !readyBusyN) protoErr++;
      statusOut = (pins.dqOut == CMD_RD_STATUS);
      if (pins.dqOut == CMD_SET_FEAT || pins.dqOut == CMD_GET_FEAT) cmd = pins.dqOut;
      else if (pins.dqOut != CMD_RD_STATUS && pins.dqOut != CMD_RD_MODE) cmd = 8'h0;
    end else if (pins.ale === 1'b1) begin
      fa = pins.dqOut;
      addrTime = $realtime;
      nParam = 0;
      if (idx(fa) < 0) protoErr++;
      else if (cmd == CMD_GET_FEAT) begin
        shift = mem[idx(fa)];
        go_busy(FEAT_NS);
      end
    end else if (pins.dqOe === 1'b0 && cmd == CMD_SET_FEAT && idx(fa) >= 0) begin
      if (nParam == 0 && $realtime - addrTime < ADL_NS) protoErr++;
      shift = {pins.dqOut, shift[31:8]};
      nParam++;
      if (nParam == 4) begin
        stReady = 8'hE0;
        if (fa == FA_TIMING && shift != mem[0]) go_busy(ITC_NS);
        else if (fa == FA_ARRAY && shift[4] && lockOff) begin
          stReady = 8'h60;
          go_busy(mem[3][3] ? 2 * OBSY_NS : OBSY_NS);
        end else go_busy(FEAT_NS);
        if (fa == FA_ARRAY && shift[4]) lockOff = 1'b1;
        mem[idx(fa)] = shift;
      end
    end
  end
  always @(posedge pins.read_strobe_n) begin
    lastOut = driven;
    if (cmd == CMD_GET_FEAT && !statusOut) begin
      if (busy) protoErr++;
      shift = {8'h0, shift[31:8]};
    end
  end
endmodule : nfc_flash_model
`default_nettype wire

// [verification/test_nfc_host.sv]
// Self-checking bench for the feature set/get host controller
`timescale 1ns/1ps
`default_nettype none
module test_nfc_host
  import nfc_pkg::*;
;
  logic clk, nrst, wbCyc, wbStb, wbWe, holdBusy, rdChk, wbAck, readyBusyN;
  logic [7:0] wbAdr, dqIn, protoErr, r;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rdVal;
  nfc_pins_type pins;
  int fails = 0;
  int check_count = 0;
  logic [31:0] expQ [$];
  logic [7:0] resetList [4] = '{FA_TIMING, FA_DRIVE, FA_RB_PULL, FA_ARRAY};
  logic [7:0] arrList [6] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h02, 8'h10};
  logic [7:0] arrExp [6] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h00, 8'h10};
  nfc_host nfc_host_i (.clk(clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .pins(pins), .dqIn(dqIn), .readyBusyN(readyBusyN));
  nfc_flash_model nfc_flash_model_i (.pins(pins), .dqIn(dqIn), .readyBusyN(readyBusyN),
    .holdBusy(holdBusy), .protoErr(protoErr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Read results are matched in order against the notes left by the driver
  always @(posedge clk) begin
    if (rdChk && wbAck === 1'b1) check(wbDatR, expQ.pop_front());
  end
  task wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      input logic chk, input logic [31:0] exp);
    if (chk) expQ.push_back(exp);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    rdChk <= chk & ~we;
    do @(posedge clk); while (wbAck !== 1'b1);
    rdVal = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    rdChk <= 1'b0;
  endtask : wb_cycle
  task run_op(input logic [7:0] fa, input logic [7:0] val, input logic get, input logic poll);
    wb_cycle(1'b1, REG_ADDR, {24'h0, fa}, 1'b0, 32'h0);
    wb_cycle(1'b1, REG_WDATA, {24'h0, val}, 1'b0, 32'h0);
    wb_cycle(1'b1, REG_CTRL, {29'h0, poll, get, 1'b1}, 1'b0, 32'h0);
    rdVal = 32'h1;
    while (rdVal[0] !== 1'b0) wb_cycle(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0);
  endtask : run_op
  // Set then get with opposite completion methods, so both busy paths are used
  task set_get(input logic [7:0] fa, input logic [7:0] val, input logic [7:0] exp,
      input logic poll);
    run_op(fa, val, 1'b0, poll);
    run_op(fa, 8'h00, 1'b1, ~poll);
    wb_cycle(1'b0, REG_RDATA, 32'h0, 1'b1, {24'h0, exp});
  endtask : set_get
  initial begin
    nrst = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hF;
    wbDatW = 32'h0;
    holdBusy = 1'b0;
    rdChk = 1'b0;
    void'($urandom(32'h05A8));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    wb_cycle(1'b0, 8'h14, 32'h0, 1'b1, 32'h0);
    wb_cycle(1'b0, REG_STATUS, 32'h0, 1'b1, 32'h0);
    run_op(8'h05, 8'h00, 1'b0, 1'b0);
    foreach (resetList[i]) begin
      run_op(resetList[i], 8'h00, 1'b1, 1'b0);
      wb_cycle(1'b0, REG_RDATA, 32'h0, 1'b1, 32'h0);
    end
    for (int i = 0; i < 6; i++) set_get(FA_TIMING, 8'(i), 8'(i), 1'(i));
    set_get(FA_TIMING, 8'h07, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) set_get(FA_DRIVE, 8'(i), 8'(i), 1'(i));
    set_get(FA_RB_PULL, 8'h02, 8'h02, 1'b1);
    foreach (arrList[i]) set_get(FA_ARRAY, arrList[i], arrExp[i], 1'(i));
    run_op(FA_ARRAY, 8'h10, 1'b0, 1'b1);
    wb_cycle(1'b0, REG_STATUS, 32'h0, 1'b1, 32'h0000_6004);
    wb_cycle(1'b0, REG_ADDR, 32'h0, 1'b1, {24'h0, FA_ARRAY});
    wb_cycle(1'b0, REG_WDATA, 32'h0, 1'b1, 32'h0000_0010);
    wb_cycle(1'b0, REG_CTRL, 32'h0, 1'b1, 32'h0);
    repeat (4) begin
      r = 8'($urandom % 6);
      set_get(FA_TIMING, r, r, r[0]);
      r = 8'($urandom % 4);
      set_get(FA_DRIVE, r, r, r[1]);
    end
    holdBusy <= 1'b1;
    run_op(FA_TIMING, 8'h00, 1'b1, 1'b0);
    wb_cycle(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0);
    check(rdVal & 32'h3, 32'h2);
    holdBusy <= 1'b0;
    check({24'h0, protoErr}, 32'h0);
    complete_run();
  end
  // Normal run needs about 100 us; a hang is cut well after that
  initial begin
    #600000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : test_nfc_host
`default_nettype wire
